/* File: dv/acc_analog_model.sv */
// Analog inputs, comparator and RC oscillator beside the converter
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    input wire logic [2:0] chan_sel, // Selected input
    input wire logic [acc_pkg::RESULT_W-1:0] dac_code, // Trial code
    input wire logic conv_power, // Converter powered
    output logic rc_clk_pin, // Free-running RC clock
    output logic comp_pin // Comparator decision
);
    logic [acc_pkg::RESULT_W-1:0] level [8]; // Input levels in code units
    initial begin
        rc_clk_pin = 1'b0;
        for (int i = 0; i < 8; i++)
            level[i] = 10'h000;
    end
    // Period unrelated to the system clock so the synchroniser is exercised
    always #37 rc_clk_pin = ~rc_clk_pin;
    // Unpowered comparator output is meaningless, so it toggles
    assign comp_pin = conv_power ? (level[chan_sel] >= dac_code) : rc_clk_pin;
endmodule
`default_nettype wire

/* File: dv/acc_top_asserts.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_asserts #(
    parameter int NUM_INPUTS = 8 // Analog inputs
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic sleep, // Sleep
    input wire logic rc_clk_pin, // RC clock
    input wire logic comp_pin, // Comparator
    input wire logic [2:0] chan_sel, // Channel
    input wire logic [acc_pkg::RESULT_W-1:0] dac_code, // Trial code
    input wire logic sample_hold, // Sampling
    input wire logic conv_power, // Power
    input wire logic ref_hi_pin_sel, // High reference
    input wire logic ref_lo_pin_sel, // Low reference
    input wire logic [NUM_INPUTS-1:0] analog_pin_en, // Analog pins
    input wire logic irq // Interrupt
);
    localparam logic [7:0] A_MAIN = {acc_pkg::IDX_MAIN, 2'h0};
    localparam logic [7:0] A_SEC = {acc_pkg::IDX_SECOND, 2'h0};
    localparam logic [7:0] A_MASK = {acc_pkg::IDX_IRQ_MASK, 2'h0};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wdone;
    logic mapped;
    assign wdone = psel && penable && pready && pwrite;
    assign mapped = paddr[1:0] == 2'h0 && paddr >= A_MAIN && paddr <= A_MASK;
    // Reference pins three and two leave the analog set while used as references
    function automatic logic [NUM_INPUTS-1:0] pins(input logic [5:0] k);
        for (int i = 0; i < NUM_INPUTS; i++)
            pins[i] = (i < NUM_INPUTS - int'(k[3:0])) && !(i == 3 && k[5]) && !(i == 2 && k[4]);
    endfunction
    AST_ZERO_WAIT: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
        else $error("access cycle without ready");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error outside completion");
    AST_UNMAPPED: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access refused");
    AST_BIT1_ZERO: assert property (pready && !pwrite && paddr == A_MAIN |-> !prdata[1])
        else $error("unused main bit reads one");
    AST_POWER_WRITE: assert property (wdone && paddr == A_MAIN |=> conv_power == $past(pwdata[0]))
        else $error("power output does not follow write");
    AST_REF_SEL: assert property (wdone && paddr == A_SEC |=>
        {ref_hi_pin_sel, ref_lo_pin_sel} == $past(pwdata[5:4])) else $error("reference select");
    AST_PIN_CFG: assert property (wdone && paddr == A_SEC |=>
        analog_pin_en == pins($past(pwdata[5:0]))) else $error("pin configuration");
    AST_IRQ_MASKED: assert property (wdone && paddr == A_MASK && !pwdata[0] |=> !irq)
        else $error("interrupt high while masked");
    AST_FIRST_TRIAL: assert property ($fell(sample_hold) && conv_power |->
        ##[0:1] dac_code == 10'h200) else $error("first trial is not midscale");
    cover property (wdone && paddr == A_MAIN && pwdata[2]);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule
bind acc_top acc_top_asserts #(.NUM_INPUTS(NUM_INPUTS)) chk_u (
    .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep(sleep), .rc_clk_pin(rc_clk_pin), .comp_pin(comp_pin),
    .chan_sel(chan_sel), .dac_code(dac_code), .sample_hold(sample_hold),
    .conv_power(conv_power), .ref_hi_pin_sel(ref_hi_pin_sel),
    .ref_lo_pin_sel(ref_lo_pin_sel), .analog_pin_en(analog_pin_en), .irq(irq));
`default_nettype wire

/* File: dv/adc_conversion_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
    typedef struct {logic [7:0] d; logic [7:0] m; logic e;} acc_exp_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sleep = 1'b0;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rc_clk, comp, shold, pwr, rhi, rlo, irq;
    logic [2:0] chan;
    logic [9:0] dac;
    logic [7:0] apin;
    int failures = 0;
    int tests_run = 0;
    acc_exp_t q[$];
    always #5 core_clk = ~core_clk;
    acc_top #(.NUM_INPUTS(8)) dut_u (
        .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep(sleep), .rc_clk_pin(rc_clk), .comp_pin(comp),
        .chan_sel(chan), .dac_code(dac), .sample_hold(shold), .conv_power(pwr),
        .ref_hi_pin_sel(rhi), .ref_lo_pin_sel(rlo), .analog_pin_en(apin), .irq(irq));
    acc_analog_model model_u (.chan_sel(chan), .dac_code(dac), .conv_power(pwr),
        .rc_clk_pin(rc_clk), .comp_pin(comp));
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        tests_run++;
        if (a !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Request holds until the rising edge that samples pready high; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d,
            input logic [7:0] m, input logic e);
        q.push_back('{d, m, e});
        @(posedge core_clk);
        paddr <= {i, 2'h0};
        pwrite <= w;
        pwdata <= {24'h0, d};
        psel <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, i, d, 8'h00, 1'b0);
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, i, e, 8'hFF, 1'b0);
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask
    always @(negedge core_clk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            chk({24'h0, prdata[7:0] & q[0].m}, {24'h0, q[0].d & q[0].m});
            chk({31'h0, pslverr}, {31'h0, q[0].e});
            q.delete(0);
        end
    end
    task automatic conv(input logic [1:0] cd, input logic ex, input logic j);
        logic [2:0] ch;
        logic [9:0] lv;
        ch = 3'($urandom_range(7));
        lv = 10'($urandom_range(1023));
        model_u.level[ch] = lv;
        wr(acc_pkg::IDX_SECOND, {j, ex, 6'h00});
        wr(acc_pkg::IDX_MAIN, {cd, ch, 3'h1});
        wr(acc_pkg::IDX_MAIN, {cd, ch, 3'h5});
        rd(acc_pkg::IDX_MAIN, {cd, ch, 3'h5});
        wait_irq(2000);
        chk({31'h0, irq}, 32'h1);
        rd(acc_pkg::IDX_MAIN, {cd, ch, 3'h1});
        rd(acc_pkg::IDX_RES_HI, j ? {6'h00, lv[9:8]} : lv[9:2]);
        rd(acc_pkg::IDX_RES_LO, j ? lv[7:0] : {lv[1:0], 6'h00});
        wr(acc_pkg::IDX_IRQ_STAT, 8'h01);
    endtask
    initial begin
        logic [7:0] c;
        void'($urandom(32'h6dd9));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(acc_pkg::IDX_MAIN, 8'h00);
        rd(acc_pkg::IDX_SECOND, 8'h00);
        rd(acc_pkg::IDX_IRQ_STAT, 8'h00);
        apb(1'b0, 6'h3F, 8'h00, 8'hFF, 1'b1);
        wr(acc_pkg::IDX_MAIN, 8'hFA);
        rd(acc_pkg::IDX_MAIN, 8'hF8);
        c = 8'($urandom());
        wr(acc_pkg::IDX_SECOND, c);
        rd(acc_pkg::IDX_SECOND, c);
        wr(acc_pkg::IDX_IRQ_MASK, 8'h01);
        for (int k = 0; k < 7; k++) begin
            sleep <= (k == 6);
            conv((k == 6) ? 2'h3 : 2'(k % 3), k >= 3 && k < 6, k[0]);
        end
        // Divided clock stops in sleep, so the conversion must stall
        wr(acc_pkg::IDX_SECOND, 8'h00);
        wr(acc_pkg::IDX_MAIN, 8'h01);
        wr(acc_pkg::IDX_MAIN, 8'h05);
        repeat (300) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rd(acc_pkg::IDX_MAIN, 8'h05);
        sleep <= 1'b0;
        wait_irq(2000);
        wr(acc_pkg::IDX_IRQ_MASK, 8'h00);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rd(acc_pkg::IDX_IRQ_STAT, 8'h01);
        wr(acc_pkg::IDX_IRQ_MASK, 8'h01);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(acc_pkg::IDX_IRQ_STAT, 8'h01);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        // Abort after the sample phase on the slowest clock
        wr(acc_pkg::IDX_SECOND, 8'h40);
        wr(acc_pkg::IDX_MAIN, 8'h81);
        wr(acc_pkg::IDX_MAIN, 8'h85);
        // Clock enable low freezes the conversion well past its normal length
        ce <= 1'b0;
        repeat (1000) @(posedge core_clk);
        ce <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        rd(acc_pkg::IDX_MAIN, 8'h85);
        repeat (200) @(posedge core_clk);
        wr(acc_pkg::IDX_MAIN, 8'h81);
        repeat (1500) @(posedge core_clk);
        rd(acc_pkg::IDX_IRQ_STAT, 8'h00);
        rd(acc_pkg::IDX_MAIN, 8'h81);
        wr(acc_pkg::IDX_MAIN, 8'h85);
        wr(acc_pkg::IDX_MAIN, 8'h00);
        rd(acc_pkg::IDX_MAIN, 8'h00);
        chk(32'(q.size()), 32'h0);
        final_report;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        final_report;
    end
endmodule
`default_nettype wire

/* File: hdl/acc_clkdiv.sv */
// Conversion clock tick generator: system clock divider or internal RC clock
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic run, // Conversion active
    input wire logic [1:0] clk_code, // conv_clock_select
    input wire logic clk_ext, // conv_clock_select_ext
    input wire logic sleep, // Device asleep, system clock gated
    input wire logic rc_clk_pin, // internal_rc_conv_clock, asynchronous
    output logic tick // One-cycle conversion clock tick
);
    logic [2:0] rc_sync;
    logic rc_level;
    logic next_rc_level;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [5:0] limit;
    logic use_rc;

    assign use_rc = (clk_code == acc_pkg::CLK_CODE_RC);
    // Divide by 2^(1 + 2*code + ext): 2,8,32 or 4,16,64
    assign limit = 6'((7'h1 << (3'h1 + {clk_code, 1'b0} + {2'h0, clk_ext})) - 7'h1);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rc_sync <= 3'h0;
        end else if (ce) begin
            rc_sync <= {rc_sync[1:0], rc_clk_pin};
        end
    end

    always_comb begin
        next_rc_level = rc_level;
        if (rc_sync[1] == rc_sync[2]) begin
            next_rc_level = rc_sync[2];
        end
        next_cnt = cnt;
        if (!run || use_rc) begin
            next_cnt = 6'h00;
        end else if (!sleep) begin
            next_cnt = (cnt >= limit) ? 6'h00 : cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rc_level <= 1'b0;
            cnt <= 6'h00;
        end else if (ce) begin
            rc_level <= next_rc_level;
            cnt <= next_cnt;
        end
    end

    // The system clock stops in sleep, so only the RC source keeps ticking
    always_comb begin
        if (!run) begin
            tick = 1'b0;
        end else if (use_rc) begin
            tick = next_rc_level & ~rc_level;
        end else begin
            tick = !sleep && (cnt >= limit);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/acc_pkg.sv */
// Shared constants for the converter control block
package acc_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_MAIN = 6'h1F;
    localparam logic [5:0] IDX_SECOND = 6'h20;
    localparam logic [5:0] IDX_RES_HI = 6'h21;
    localparam logic [5:0] IDX_RES_LO = 6'h22;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h23;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h24;
    // Main control fields
    localparam int MAIN_CLK_LSB = 6;
    localparam int MAIN_CHAN_LSB = 3;
    localparam int MAIN_GO_BIT = 2;
    localparam int MAIN_PWR_BIT = 0;
    localparam logic [7:0] MAIN_WMASK = 8'hFD;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    // Second control fields
    localparam int SEC_JUST_BIT = 7;
    localparam int SEC_EXT_BIT = 6;
    localparam int SEC_VHI_BIT = 5;
    localparam int SEC_VLO_BIT = 4;
    localparam int SEC_CFG_LSB = 0;
    localparam logic [7:0] SEC_RESET = 8'h00;
    // Interrupt status and mask
    localparam int IRQ_DONE_BIT = 0;
    localparam logic [7:0] IRQ_WMASK = 8'h01;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    // Conversion
    localparam int RESULT_W = 10;
    localparam logic [1:0] CLK_CODE_RC = 2'h3;
    localparam logic [2:0] SETTLE_CYC = 3'h4;
    localparam logic [3:0] REF_HI_PIN = 4'h3;
    localparam logic [3:0] REF_LO_PIN = 4'h2;
endpackage

/* File: hdl/acc_sar.sv */
// Successive approximation sequencer: one sample tick then one bit per tick arriving after the settle delay
`timescale 1ns/1ps
`default_nettype none
module acc_sar #(
    parameter int WIDTH = 10 // Result width
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic start, // Begin conversion, pulse
    input wire logic abort, // Drop conversion, pulse
    input wire logic tick, // Conversion clock tick
    input wire logic comp, // Comparator: input at or above trial code
    output logic busy, // Conversion running
    output logic done, // Result valid, one-cycle pulse
    output logic [WIDTH-1:0] result, // Final code
    output logic [WIDTH-1:0] trial, // Code to the DAC
    output logic sample // Sample-and-hold tracking
);
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BITS} acc_sar_state_t;
    acc_sar_state_t state;
    acc_sar_state_t next_state;
    logic [WIDTH-1:0] next_trial;
    logic [WIDTH-1:0] next_result;
    logic [$clog2(WIDTH)-1:0] bit_idx;
    logic [$clog2(WIDTH)-1:0] next_bit_idx;
    logic [2:0] settle;
    logic [2:0] next_settle;
    logic next_done;
    logic [WIDTH-1:0] kept;

    always_comb begin
        next_state = state;
        next_trial = trial;
        next_result = result;
        next_bit_idx = bit_idx;
        next_done = 1'b0;
        next_settle = (settle != 3'h0) ? settle - 3'h1 : 3'h0;
        kept = comp ? trial : (trial & ~(WIDTH'(1) << bit_idx));
        case (state)
            SAR_IDLE: begin
                if (start && !abort) begin
                    next_state = SAR_SAMPLE;
                    next_trial = '0;
                end
            end
            SAR_SAMPLE: begin
                if (tick) begin
                    next_state = SAR_BITS;
                    next_bit_idx = ($clog2(WIDTH))'(WIDTH - 1);
                    next_trial = WIDTH'(1) << (WIDTH - 1);
                    next_settle = acc_pkg::SETTLE_CYC;
                end
            end
            default: begin
                // The comparator reaches us through a synchroniser; wait it out
                if (tick && settle == 3'h0) begin
                    if (bit_idx == '0) begin
                        next_state = SAR_IDLE;
                        next_result = kept;
                        next_done = 1'b1;
                    end else begin
                        next_bit_idx = bit_idx - 1'b1;
                        next_trial = kept | (WIDTH'(1) << (bit_idx - 1'b1));
                        next_settle = acc_pkg::SETTLE_CYC;
                    end
                end
            end
        endcase
        if (abort) begin
            next_state = SAR_IDLE;
            next_done = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= SAR_IDLE;
            trial <= '0;
            result <= '0;
            bit_idx <= '0;
            settle <= 3'h0;
            done <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            trial <= next_trial;
            result <= next_result;
            bit_idx <= next_bit_idx;
            settle <= next_settle;
            done <= next_done;
        end
    end

    assign busy = (state != SAR_IDLE);
    assign sample = (state == SAR_SAMPLE);
endmodule
`default_nettype wire

/* File: hdl/acc_top.sv */
// Converter control block: APB registers, clock select, sequencing, interrupt
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each conversion yields a ten-bit result
// - Five inputs small variant, eight large
// - Sleep conversions only with RC clock
// - Clock code with ext 0: /2 /8 /32
// - Ext 1: /4 /16 /64; 11 is RC
// - Channel field bits 5-3 selects input
// - Writing go while powered starts conversion
// - Hardware clears go flag on completion
// - Bit 1 reads zero, writes ignored
// - Power bit on; cleared shuts converter off
// - References selectable: rails or two pins
// - Second register sets pins analog/digital
// - Six converter registers visible to software
module acc_top #(
    parameter int NUM_INPUTS = 8 // Analog inputs: 8 large variant, 5 small
) (
    input wire logic core_clk, // 100 MHz system clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic sleep, // Device in sleep
    input wire logic rc_clk_pin, // internal_rc_conv_clock
    input wire logic comp_pin, // Comparator output, asynchronous
    output logic [2:0] chan_sel, // input_channel_select to analog mux
    output logic [acc_pkg::RESULT_W-1:0] dac_code, // Trial code to DAC
    output logic sample_hold, // Sample switch closed
    output logic conv_power, // converter_power_on to analog
    output logic ref_hi_pin_sel, // Vref+ from port_a_pin_three, else supply
    output logic ref_lo_pin_sel, // Vref- from port_a_pin_two, else ground
    output logic [NUM_INPUTS-1:0] analog_pin_en, // Pin is analog input
    output logic irq // Interrupt, level
);
    logic [7:0] converter_control_main;
    logic [7:0] next_main;
    logic [7:0] converter_control_second;
    logic [7:0] next_second;
    logic [7:0] irq_status;
    logic [7:0] next_irq_status;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic rd_ok;
    logic next_rd_ok;
    logic addr_ok;
    logic next_addr_ok;
    logic [2:0] comp_sync;
    logic comp_level;
    logic next_comp_level;
    logic done_d;
    logic wr;
    logic [7:0] wbyte;
    logic [5:0] idx;
    logic go_req;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic tick;
    logic [acc_pkg::RESULT_W-1:0] result;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic powered;

    assign idx = paddr[7:2];
    assign wbyte = pwdata[7:0];
    assign powered = converter_control_main[acc_pkg::MAIN_PWR_BIT];
    assign pready = psel & penable & rd_ok & ce;
    assign pslverr = pready & ~addr_ok;
    assign wr = pready & pwrite & addr_ok;
    assign go_req = wr && idx == acc_pkg::IDX_MAIN && wbyte[acc_pkg::MAIN_GO_BIT];
    assign start = go_req && powered && wbyte[acc_pkg::MAIN_PWR_BIT] && !busy;
    // Power off, or software clearing go, drops a conversion in flight
    assign abort = busy && (!powered || (wr && idx == acc_pkg::IDX_MAIN
        && (!wbyte[acc_pkg::MAIN_GO_BIT] || !wbyte[acc_pkg::MAIN_PWR_BIT])));

    // Comparator sync; level accepted once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            comp_sync <= 3'h0;
        end else if (ce) begin
            comp_sync <= {comp_sync[1:0], comp_pin};
        end
    end

    always_comb begin
        next_comp_level = comp_level;
        if (comp_sync[1] == comp_sync[2]) begin
            next_comp_level = comp_sync[2];
        end
    end

    // Result formatting: right-justified or left-justified in the two bytes
    always_comb begin
        if (converter_control_second[acc_pkg::SEC_JUST_BIT]) begin
            result_high_byte = {6'h00, result[9:8]};
            result_low_byte = result[7:0];
        end else begin
            result_high_byte = result[9:2];
            result_low_byte = {result[1:0], 6'h00};
        end
    end

    // Register state
    always_comb begin
        next_main = converter_control_main;
        next_second = converter_control_second;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr) begin
            if (idx == acc_pkg::IDX_MAIN) begin
                // Go bit is set only through start; bit 1 stays zero
                next_main = wbyte & acc_pkg::MAIN_WMASK
                    & ~(8'h01 << acc_pkg::MAIN_GO_BIT);
                next_main[acc_pkg::MAIN_GO_BIT] = converter_control_main[acc_pkg::MAIN_GO_BIT];
            end else if (idx == acc_pkg::IDX_SECOND) begin
                next_second = wbyte;
            end else if (idx == acc_pkg::IDX_IRQ_STAT) begin
                next_irq_status = irq_status & ~(wbyte & acc_pkg::IRQ_WMASK);
            end else if (idx == acc_pkg::IDX_IRQ_MASK) begin
                next_irq_mask = wbyte & acc_pkg::IRQ_WMASK;
            end
        end
        // Result was loaded on done; the flag falls two cycles later
        if (done_d || abort || !next_main[acc_pkg::MAIN_PWR_BIT]) begin
            next_main[acc_pkg::MAIN_GO_BIT] = 1'b0;
        end
        // A start in the completion cycle wins; a conversion started while done is high reads idle after done_d clears go
        if (start) begin
            next_main[acc_pkg::MAIN_GO_BIT] = 1'b1;
        end
        if (done) begin
            next_irq_status[acc_pkg::IRQ_DONE_BIT] = 1'b1;
        end
    end

    // APB read path; data captured in the setup cycle, zero wait states
    always_comb begin
        next_prdata = prdata;
        next_rd_ok = rd_ok;
        next_addr_ok = addr_ok;
        if (psel && !penable) begin
            next_rd_ok = 1'b1;
            next_addr_ok = 1'b1;
            next_prdata = 32'h0000_0000;
            if (idx == acc_pkg::IDX_MAIN) begin
                next_prdata[7:0] = converter_control_main;
            end else if (idx == acc_pkg::IDX_SECOND) begin
                next_prdata[7:0] = converter_control_second;
            end else if (idx == acc_pkg::IDX_RES_HI) begin
                next_prdata[7:0] = result_high_byte;
            end else if (idx == acc_pkg::IDX_RES_LO) begin
                next_prdata[7:0] = result_low_byte;
            end else if (idx == acc_pkg::IDX_IRQ_STAT) begin
                next_prdata[7:0] = irq_status;
            end else if (idx == acc_pkg::IDX_IRQ_MASK) begin
                next_prdata[7:0] = irq_mask;
            end else begin
                next_addr_ok = 1'b0;
            end
        end else if (pready) begin
            next_rd_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            converter_control_main <= acc_pkg::MAIN_RESET;
            converter_control_second <= acc_pkg::SEC_RESET;
            irq_status <= acc_pkg::IRQ_RESET;
            irq_mask <= acc_pkg::IRQ_RESET;
            prdata <= 32'h0000_0000;
            rd_ok <= 1'b0;
            addr_ok <= 1'b0;
            comp_level <= 1'b0;
            done_d <= 1'b0;
        end else if (ce) begin
            converter_control_main <= next_main;
            converter_control_second <= next_second;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            rd_ok <= next_rd_ok;
            addr_ok <= next_addr_ok;
            comp_level <= next_comp_level;
            done_d <= done;
        end
    end

    assign irq = |(irq_status & irq_mask);

    acc_clkdiv u_clkdiv (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .run(busy),
        .clk_code(converter_control_main[acc_pkg::MAIN_CLK_LSB +: 2]),
        .clk_ext(converter_control_second[acc_pkg::SEC_EXT_BIT]),
        .sleep(sleep),
        .rc_clk_pin(rc_clk_pin),
        .tick(tick)
    );

    acc_sar #(
        .WIDTH(acc_pkg::RESULT_W)
    ) u_sar (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .start(start),
        .abort(abort),
        .tick(tick),
        .comp(comp_level),
        .busy(busy),
        .done(done),
        .result(result),
        .trial(dac_code),
        .sample(sample_hold)
    );

    // Analog side controls
    assign chan_sel = converter_control_main[acc_pkg::MAIN_CHAN_LSB +: 3];
    assign conv_power = powered;
    assign ref_hi_pin_sel = converter_control_second[acc_pkg::SEC_VHI_BIT];
    assign ref_lo_pin_sel = converter_control_second[acc_pkg::SEC_VLO_BIT];

    // Config k leaves the top k pins digital; a reference pin is never an input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_pin
            always_comb begin
                analog_pin_en[gi] = (32'(gi) + 32'(converter_control_second[3:0])) < 32'(NUM_INPUTS);
                if (gi == int'(acc_pkg::REF_HI_PIN) && ref_hi_pin_sel) begin
                    analog_pin_en[gi] = 1'b0;
                end
                if (gi == int'(acc_pkg::REF_LO_PIN) && ref_lo_pin_sel) begin
                    analog_pin_en[gi] = 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
